// ### src/smr_pkg.sv
// Constants for the speed-mode ramp profile block
package smr_pkg;
    localparam int NUM_SLOTS  = 28;
    localparam int MODE_SLOTS = 13;
    // Slot positions within one speed mode; the two band thresholds are shared slots 26 and 27
    localparam int SL_FWD_TOP   = 0;
    localparam int SL_FWD_START = 1;
    localparam int SL_REV_TOP   = 2;
    localparam int SL_REV_START = 3;
    localparam int SL_ACC_FAST  = 4;
    localparam int SL_ACC_SLOW  = 5;
    localparam int SL_NEU_FAST  = 6;
    localparam int SL_NEU_SLOW  = 7;
    localparam int SL_BRK_FAST  = 8;
    localparam int SL_BRK_SLOW  = 9;
    localparam int SL_PART      = 10;
    localparam int SL_LT_ACC    = 11;
    localparam int SL_LT_BRK    = 12;
    localparam int SL_FAST_THR  = 26;
    localparam int SL_SLOW_THR  = 27;

    // Parameter object indices, mode 1 slots 0..12, mode 2 slots 13..25
    localparam logic [23:0] PARAM_INDEX [0:NUM_SLOTS-1] = '{
        24'h380001, 24'h380101, 24'h380201, 24'h380301,
        24'h381201, 24'h381301, 24'h381401, 24'h381501,
        24'h381601, 24'h381701, 24'h381801, 24'h381901, 24'h381a01,
        24'h380701, 24'h380801, 24'h380901, 24'h380a01,
        24'h381b01, 24'h381c01, 24'h381d01, 24'h381e01,
        24'h381f01, 24'h382001, 24'h382101, 24'h382201, 24'h382301,
        24'h382401, 24'h382501};

    localparam logic [15:0] SPEED_TOP_RST   = 16'h2000;
    localparam logic [15:0] SPEED_START_RST = 16'h0000;
    localparam logic [15:0] RAMP_RST        = 16'h05dc;
    localparam logic [15:0] FAST_THR_RST    = 16'h7333;
    localparam logic [15:0] SLOW_THR_RST    = 16'h0ccd;

    localparam logic [15:0] PARAM_RESET [0:NUM_SLOTS-1] = '{
        SPEED_TOP_RST, SPEED_START_RST, SPEED_TOP_RST, SPEED_START_RST,
        RAMP_RST, RAMP_RST, RAMP_RST, RAMP_RST, RAMP_RST,
        RAMP_RST, RAMP_RST, RAMP_RST, RAMP_RST,
        SPEED_TOP_RST, SPEED_START_RST, SPEED_TOP_RST, SPEED_START_RST,
        RAMP_RST, RAMP_RST, RAMP_RST, RAMP_RST, RAMP_RST,
        RAMP_RST, RAMP_RST, RAMP_RST, RAMP_RST,
        FAST_THR_RST, SLOW_THR_RST};

    // Objects that only take effect after a key cycle: speed limits of both modes
    localparam logic [NUM_SLOTS-1:0] RESTART_MASK = 28'h001e00f;

    localparam int          SPEED_FRAC   = 8;
    localparam int          THR_SHIFT    = 13;
    localparam int          PCT_SHIFT    = 15;
    localparam logic [15:0] SPEED_FULL   = 16'h2000;
    localparam logic [15:0] THR_FULL     = 16'h2000;
    localparam logic [15:0] RAMP_MIN     = 16'h0032;
    localparam logic [15:0] RAMP_MAX     = 16'h0fa0;
    // Full-scale travel in fixed point; divided by ramp raw gives step per tick
    localparam logic [31:0] FULL_FX      = 32'h0020_0000;

    localparam int CLK_PERIOD_NS = 20;
    localparam int RAMP_UNIT_US  = 2000;
    localparam int TICK_CYCLES   = RAMP_UNIT_US * 1000 / CLK_PERIOD_NS;
    localparam int DIV_BITS      = 32;
endpackage : smr_pkg

// ### src/smr_divider.sv
// Sequential restoring divider, one quotient bit per clock
`timescale 1ns/100ps
`default_nettype none
module smr_divider #(
    parameter int W = 32
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         start,
    input  wire logic [W-1:0] num,
    input  wire logic [15:0]  den,
    output logic              busy,
    output logic              done,
    output logic [W-1:0]      quo
);
    logic [W-1:0] numQ;
    logic [16:0]  remQ;
    logic [15:0]  denQ;
    logic [5:0]   cntQ;
    logic [16:0]  trial;

    assign trial = {remQ[15:0], numQ[W-1]};

    always_ff @(posedge clk) begin
        if (rst) begin
            numQ <= '0;
            remQ <= '0;
            denQ <= '0;
            cntQ <= '0;
            busy <= 1'b0;
            done <= 1'b0;
            quo  <= '0;
        end else begin
            done <= 1'b0;
            if (start && !busy) begin
                numQ <= num;
                remQ <= '0;
                denQ <= den;
                cntQ <= 6'(W);
                busy <= 1'b1;
            end else if (busy) begin
                if (trial >= {1'b0, denQ}) begin
                    remQ <= trial - {1'b0, denQ};
                    numQ <= {numQ[W-2:0], 1'b1};
                end else begin
                    remQ <= trial;
                    numQ <= {numQ[W-2:0], 1'b0};
                end
                cntQ <= cntQ - 6'h01;
                if (cntQ == 6'h01) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                    quo  <= (trial >= {1'b0, denQ}) ? {numQ[W-2:0], 1'b1}
                                                    : {numQ[W-2:0], 1'b0};
                end
            end
        end
    end
endmodule : smr_divider
`default_nettype wire

// ### src/smr_ramp_profile.sv
// Speed-mode parameter store and ramped speed target generator
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// - Changing a restart-only object without a key cycle raises the change fault.
// - Change fault stays until a key off-on cycle, then clears.
// - Two parameter sets; the selected speed mode's set is applied.
// - Speed settings are fractions of motor top speed, 8192 meaning full.
// - Full forward throttle commands the forward top speed.
// - Throttle just past forward neutral commands the forward start speed.
// - Full reverse throttle commands the reverse top speed.
// - Throttle just past reverse neutral commands the reverse start speed.
// - Full throttle at high speed uses the fast-band acceleration time.
// - Full throttle at low speed uses the slow-band acceleration time.
// - Light throttle demand uses the light-throttle acceleration time.
// - Neutral at high speed uses the fast-band neutral deceleration time.
// - Neutral at low speed uses the slow-band neutral deceleration time.
// - Full opposite throttle at high speed uses fast-band brake time.
// - Full opposite throttle at low speed uses slow-band brake time.
// - Light opposite throttle uses the light-throttle brake time.
// - Reduced but non-neutral throttle uses the partial deceleration time.
// - Fast or slow band chosen by comparing speed with the two thresholds.
// - Fast above 90 percent, slow below 10 percent of mode top, by default.
// - Between thresholds, acceleration time is interpolated linearly.
// - Between thresholds, brake time is interpolated linearly, both directions.
module smr_ramp_profile
#(
    parameter int          TICK_CYC       = smr_pkg::TICK_CYCLES,
    parameter logic [15:0] LIGHT_THROTTLE = 16'h0400
) (
    input  wire logic               clk,
    input  wire logic               rst,
    input  wire logic               wrStb,
    input  wire logic [23:0]        wrIndex,
    input  wire logic [15:0]        wrData,
    output logic                    wrAck,
    input  wire logic               rdStb,
    input  wire logic [23:0]        rdIndex,
    output logic [15:0]             rdData,
    output logic                    rdAck,
    input  wire logic               keyOnPin,
    input  wire logic               modeSelPin,
    input  wire logic signed [15:0] throttle,
    input  wire logic signed [15:0] presentSpeed,
    output logic signed [15:0]      speedTarget,
    output logic                    restartRequiredMarker
);
    import smr_pkg::*;

    typedef enum logic [1:0] {S_IDLE, S_INTERP, S_RATE, S_APPLY} smr_state_t;

    logic [15:0] storeQ [0:NUM_SLOTS-1];
    logic [15:0] actQ   [0:NUM_SLOTS-1];
    logic [1:0]  keySyncQ, modeSyncQ;
    logic        keyPrevQ, modeQ, keyRise, faultSet;
    logic        wrHit, rdHit;
    logic [4:0]  wrSlot, rdSlot;
    logic [31:0] tickCntQ;
    logic        tick;

    // Pin synchronisers; key resets to on so a release gives no false rise
    always_ff @(posedge clk) begin
        if (rst) begin
            keySyncQ  <= 2'b11;
            modeSyncQ <= 2'b00;
            keyPrevQ  <= 1'b1;
            modeQ     <= 1'b0;
        end else begin
            keySyncQ  <= {keySyncQ[0], keyOnPin};
            modeSyncQ <= {modeSyncQ[0], modeSelPin};
            keyPrevQ  <= keySyncQ[1];
            modeQ     <= modeSyncQ[1];
        end
    end
    assign keyRise = keySyncQ[1] && !keyPrevQ;

    // Index decode
    always_comb begin
        wrHit  = 1'b0;
        wrSlot = '0;
        rdHit  = 1'b0;
        rdSlot = '0;
        for (int i = 0; i < NUM_SLOTS; i++) begin
            if (wrIndex == PARAM_INDEX[i]) begin
                wrHit  = 1'b1;
                wrSlot = 5'(i);
            end
            if (rdIndex == PARAM_INDEX[i]) begin
                rdHit  = 1'b1;
                rdSlot = 5'(i);
            end
        end
    end

    // Stored copy follows writes; restart-only objects go live on key rise
    for (genvar g = 0; g < NUM_SLOTS; g++) begin : g_slot
        always_ff @(posedge clk) begin
            if (rst) begin
                storeQ[g] <= PARAM_RESET[g];
                actQ[g]   <= PARAM_RESET[g];
            end else begin
                if (wrStb && wrHit && wrSlot == 5'(g)) begin
                    storeQ[g] <= wrData;
                end
                if (RESTART_MASK[g]) begin
                    if (keyRise) begin
                        actQ[g] <= storeQ[g];
                    end
                end else if (wrStb && wrHit && wrSlot == 5'(g)) begin
                    actQ[g] <= wrData;
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wrAck  <= 1'b0;
            rdAck  <= 1'b0;
            rdData <= '0;
        end else begin
            wrAck <= wrStb && wrHit;
            rdAck <= rdStb && rdHit;
            if (rdStb) begin
                rdData <= rdHit ? storeQ[rdSlot] : 16'h0000;
            end
        end
    end

    // Change fault: a set in the clearing cycle wins
    assign faultSet = wrStb && wrHit && RESTART_MASK[wrSlot] && (wrData != actQ[wrSlot]);
    always_ff @(posedge clk) begin
        if (rst) begin
            restartRequiredMarker <= 1'b0;
        end else if (faultSet) begin
            restartRequiredMarker <= 1'b1;
        end else if (keyRise) begin
            restartRequiredMarker <= 1'b0;
        end
    end

    // Control tick
    always_ff @(posedge clk) begin
        if (rst) begin
            tickCntQ <= '0;
        end else if (tickCntQ >= 32'(TICK_CYC - 1)) begin
            tickCntQ <= '0;
        end else begin
            tickCntQ <= tickCntQ + 32'h1;
        end
    end
    assign tick = (tickCntQ == 32'(TICK_CYC - 1));

    // Requested speed from throttle
    logic [4:0]         base;
    logic [15:0]        thrMag, spdMag, topS, startS, reqMag;
    logic [26:0]        spanProd;
    logic signed [16:0] reqSpeed;
    logic [31:0]        fastProd, slowProd;
    logic [15:0]        fastSpd, slowSpd;
    assign base   = modeQ ? 5'(MODE_SLOTS) : 5'd0;
    assign thrMag = throttle[15] ? ((16'(-throttle) > THR_FULL) ? THR_FULL : 16'(-throttle))
                                 : ((throttle > $signed(THR_FULL)) ? THR_FULL : throttle);
    assign spdMag = presentSpeed[15] ? 16'(-presentSpeed) : presentSpeed;

    always_comb begin
        if (throttle < 0) begin
            topS   = actQ[base + 5'(SL_REV_TOP)];
            startS = actQ[base + 5'(SL_REV_START)];
        end else begin
            topS   = actQ[base + 5'(SL_FWD_TOP)];
            startS = actQ[base + 5'(SL_FWD_START)];
        end
        spanProd = (topS >= startS) ? 27'(topS - startS) * 27'(thrMag - 16'h0001) : 27'd0;
        reqMag   = (thrMag == THR_FULL) ? topS : 16'(startS + 16'(spanProd >> THR_SHIFT));
        if (throttle == 0) begin
            reqSpeed = 17'sd0;
        end else if (throttle < 0) begin
            reqSpeed = -$signed({1'b0, reqMag});
        end else begin
            reqSpeed = $signed({1'b0, reqMag});
        end
    end

    // Band thresholds relative to the active mode's forward top speed
    assign fastProd = 32'(actQ[SL_FAST_THR]) * 32'(actQ[base + 5'(SL_FWD_TOP)]);
    assign slowProd = 32'(actQ[SL_SLOW_THR]) * 32'(actQ[base + 5'(SL_FWD_TOP)]);
    assign fastSpd  = fastProd[PCT_SHIFT +: 16];
    assign slowSpd  = slowProd[PCT_SHIFT +: 16];

    function automatic logic [15:0] clampRamp(input logic [15:0] v);
        clampRamp = (v < RAMP_MIN) ? RAMP_MIN : ((v > RAMP_MAX) ? RAMP_MAX : v);
    endfunction : clampRamp

    // Choice of ramp setting for the present situation
    logic signed [23:0] tgtQ;
    logic               dirOpp, banded, accelDir;
    logic [4:0]         fastSl, slowSl;
    logic [15:0]        fastT, slowT;

    assign dirOpp   = (throttle > 0 && presentSpeed < 0) || (throttle < 0 && presentSpeed > 0);
    assign accelDir = (reqSpeed >= 0) ? (24'(reqSpeed) <<< SPEED_FRAC) >= tgtQ
                                      : (24'(reqSpeed) <<< SPEED_FRAC) <= tgtQ;
    always_comb begin
        banded = 1'b1;
        fastSl = base + 5'(SL_NEU_FAST);
        slowSl = base + 5'(SL_NEU_SLOW);
        if (throttle != 0) begin
            if (dirOpp) begin
                if (thrMag <= LIGHT_THROTTLE) begin
                    banded = 1'b0;
                    fastSl = base + 5'(SL_LT_BRK);
                end else begin
                    fastSl = base + 5'(SL_BRK_FAST);
                    slowSl = base + 5'(SL_BRK_SLOW);
                end
            end else if (accelDir) begin
                if (thrMag <= LIGHT_THROTTLE) begin
                    banded = 1'b0;
                    fastSl = base + 5'(SL_LT_ACC);
                end else begin
                    fastSl = base + 5'(SL_ACC_FAST);
                    slowSl = base + 5'(SL_ACC_SLOW);
                end
            end else begin
                banded = 1'b0;
                fastSl = base + 5'(SL_PART);
            end
        end
        fastT = clampRamp(actQ[fastSl]);
        slowT = clampRamp(actQ[slowSl]);
    end

    // Ramp sequencer
    smr_state_t         stQ;
    logic               divStart, divBusy, divDone, interpSel;
    logic [31:0]        divNum, divQuo;
    logic [15:0]        divDen, slowTQ, stepBaseT;
    logic               negQ;
    logic signed [23:0] reqQ, stepQ;
    logic [15:0]        spanT;
    assign spanT = (fastT >= slowT) ? fastT - slowT : slowT - fastT;
    always_comb begin
        divStart  = 1'b0;
        interpSel = 1'b0;
        divNum    = FULL_FX;
        divDen    = RAMP_MIN;
        if (stQ == S_IDLE && tick) begin
            divStart = 1'b1;
            if (!banded || spdMag >= fastSpd || fastSpd <= slowSpd) begin
                divDen = fastT;
            end else if (spdMag <= slowSpd) begin
                divDen = slowT;
            end else begin
                interpSel = 1'b1;
                divNum    = 32'(spanT) * 32'(spdMag - slowSpd);
                divDen    = fastSpd - slowSpd;
            end
        end else if (stQ == S_INTERP && divDone) begin
            divStart = 1'b1;
            divDen   = stepBaseT;
        end
    end
    assign stepBaseT = negQ ? slowTQ - divQuo[15:0] : slowTQ + divQuo[15:0];

    always_ff @(posedge clk) begin
        if (rst) begin
            stQ    <= S_IDLE;
            slowTQ <= '0;
            negQ   <= 1'b0;
            reqQ   <= '0;
            stepQ  <= '0;
        end else begin
            case (stQ)
                S_IDLE: begin
                    if (tick) begin
                        reqQ   <= 24'(reqSpeed) <<< SPEED_FRAC;
                        slowTQ <= slowT;
                        negQ   <= fastT < slowT;
                        stQ    <= interpSel ? S_INTERP : S_RATE;
                    end
                end
                S_INTERP: begin
                    if (divDone) begin
                        stQ <= S_RATE;
                    end
                end
                S_RATE: begin
                    if (divDone) begin
                        stepQ <= $signed(24'(divQuo));
                        stQ   <= S_APPLY;
                    end
                end
                S_APPLY: stQ <= S_IDLE;
                default: stQ <= S_IDLE;
            endcase
        end
    end

    smr_divider #(.W(DIV_BITS)) u_div (
        .clk   (clk),
        .rst   (rst),
        .start (divStart),
        .num   (divNum),
        .den   (divDen),
        .busy  (divBusy),
        .done  (divDone),
        .quo   (divQuo)
    );

    // Step without passing the request
    always_ff @(posedge clk) begin
        if (rst) begin
            tgtQ <= '0;
        end else if (stQ == S_APPLY) begin
            if (tgtQ < reqQ) begin
                tgtQ <= (reqQ - tgtQ > stepQ) ? tgtQ + stepQ : reqQ;
            end else begin
                tgtQ <= (tgtQ - reqQ > stepQ) ? tgtQ - stepQ : reqQ;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            speedTarget <= '0;
        end else begin
            speedTarget <= 16'(tgtQ >>> SPEED_FRAC);
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    a_fault_set: assert property (faultSet |=> restartRequiredMarker)
        else $error("change fault not raised");
    a_fault_hold: assert property (restartRequiredMarker && !keyRise |=> restartRequiredMarker)
        else $error("change fault dropped without key cycle");
    a_fault_clear: assert property (keyRise && !faultSet |=> !restartRequiredMarker)
        else $error("change fault not cleared by key cycle");
    a_live_hold: assert property (wrStb && wrHit && RESTART_MASK[wrSlot] && !keyRise
        |=> actQ[$past(wrSlot)] == $past(actQ[wrSlot]))
        else $error("restart object went live early");
    a_full_fwd: assert property (throttle == $signed(THR_FULL) && !modeQ
        |-> reqSpeed == $signed({1'b0, actQ[SL_FWD_TOP]}))
        else $error("full forward request wrong");
    a_start_rev: assert property (throttle == -16'sd1 && modeQ
        |-> reqSpeed == -$signed({1'b0, actQ[MODE_SLOTS + SL_REV_START]}))
        else $error("reverse start request wrong");
    a_no_overshoot: assert property (stQ == S_APPLY && tgtQ <= reqQ
        |=> tgtQ <= $past(reqQ) && tgtQ >= $past(tgtQ))
        else $error("ramp overshoot upward");
    a_no_undershoot: assert property (stQ == S_APPLY && tgtQ >= reqQ
        |=> tgtQ >= $past(reqQ) && tgtQ <= $past(tgtQ))
        else $error("ramp overshoot downward");
    a_div_bound: assert property (divStart && !divBusy |-> ##[33:33] divDone)
        else $error("divider latency wrong");
    a_fast_band: assert property (stQ == S_IDLE && tick && banded && spdMag >= fastSpd
        |-> divDen == fastT)
        else $error("fast band time not chosen");

    c_fault: cover property (faultSet ##[1:20] keyRise);
    c_interp: cover property (stQ == S_INTERP ##[1:80] stQ == S_APPLY);
    c_reach: cover property (stQ == S_APPLY && tgtQ != reqQ ##1 tgtQ == $past(reqQ));
endmodule : smr_ramp_profile
`default_nettype wire

// ### tb/smr_tool_model.sv
// Programming tool model issuing parameter object writes and reads
`timescale 1ns/100ps
`default_nettype none
module smr_tool_model (
    input  wire logic        clk,
    output var  logic        wrStb,
    output var  logic [23:0] wrIndex,
    output var  logic [15:0] wrData,
    input  wire logic        wrAck,
    output var  logic        rdStb,
    output var  logic [23:0] rdIndex,
    input  wire logic [15:0] rdData,
    input  wire logic        rdAck
);
    initial begin
        wrStb   = 1'b0;
        wrIndex = 24'h000000;
        wrData  = 16'h0000;
        rdStb   = 1'b0;
        rdIndex = 24'h000000;
    end

    // Idle lines show inverted leftovers, never the last value
    task automatic write_obj(input logic [23:0] idx, input logic [15:0] data,
                             output logic ack);
        @(posedge clk);
        wrStb   <= 1'b1;
        wrIndex <= idx;
        wrData  <= data;
        @(posedge clk);
        wrStb   <= 1'b0;
        wrIndex <= ~idx;
        wrData  <= ~data;
        #1;
        ack = wrAck;
    endtask : write_obj

    task automatic read_obj(input logic [23:0] idx, output logic [15:0] data,
                            output logic ack);
        @(posedge clk);
        rdStb   <= 1'b1;
        rdIndex <= idx;
        @(posedge clk);
        rdStb   <= 1'b0;
        rdIndex <= ~idx;
        #1;
        ack  = rdAck;
        data = rdData;
    endtask : read_obj
endmodule : smr_tool_model
`default_nettype wire

// ### tb/smr_ramp_profile_test.sv
// Self-checking bench for the speed-mode ramp profile block
`timescale 1ns/100ps
`default_nettype none
module smr_ramp_profile_test;
    import smr_pkg::*;
    localparam int TCYC = 200;
    logic clk, rst, wrStb, wrAck, rdStb, rdAck, keyOnPin, modeSelPin, marker;
    logic [23:0]        wrIndex, rdIndex;
    logic [15:0]        wrData, rdData;
    logic signed [15:0] throttle, presentSpeed, speedTarget;
    int                 failures = 0;
    int                 checks = 0;

    smr_ramp_profile #(.TICK_CYC(TCYC)) u_smr_ramp_profile (.clk(clk), .rst(rst),
        .wrStb(wrStb), .wrIndex(wrIndex), .wrData(wrData), .wrAck(wrAck),
        .rdStb(rdStb), .rdIndex(rdIndex), .rdData(rdData), .rdAck(rdAck),
        .keyOnPin(keyOnPin), .modeSelPin(modeSelPin), .throttle(throttle),
        .presentSpeed(presentSpeed), .speedTarget(speedTarget),
        .restartRequiredMarker(marker));
    smr_tool_model u_smr_tool_model (.clk(clk), .wrStb(wrStb), .wrIndex(wrIndex),
        .wrData(wrData), .wrAck(wrAck), .rdStb(rdStb), .rdIndex(rdIndex),
        .rdData(rdData), .rdAck(rdAck));

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic test_done();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : test_done

    task automatic wr(input logic [23:0] idx, input logic [15:0] data);
        logic ack;
        u_smr_tool_model.write_obj(idx, data, ack);
        check("write ack", 16'h0001, {15'h0000, ack});
    endtask : wr

    task automatic rd(input logic [23:0] idx, input logic [15:0] exp, input logic expAck);
        logic [15:0] data;
        logic        ack;
        u_smr_tool_model.read_obj(idx, data, ack);
        check("read ack", {15'h0000, expAck}, {15'h0000, ack});
        check("read data", exp, data);
    endtask : rd

    task automatic ticks(input int n);
        repeat (n * TCYC + 80) @(posedge clk);
        @(negedge clk);
    endtask : ticks

    task automatic drive(input logic signed [15:0] thr, input logic signed [15:0] spd);
        @(posedge clk);
        throttle     <= thr;
        presentSpeed <= spd;
    endtask : drive

    task automatic key_cycle(input logic expBefore);
        @(posedge clk);
        keyOnPin <= 1'b0;
        repeat (6) @(posedge clk);
        keyOnPin <= 1'b1;
        #1;
        check("marker key low", {15'h0000, expBefore}, {15'h0000, marker});
        repeat (6) @(posedge clk);
        #1;
        check("marker after key", 16'h0000, {15'h0000, marker});
    endtask : key_cycle

    task automatic t_defaults();
        rd(PARAM_INDEX[SL_FWD_TOP], 16'h2000, 1'b1);
        rd(PARAM_INDEX[SL_FWD_START], 16'h0000, 1'b1);
        rd(PARAM_INDEX[SL_ACC_FAST], 16'h05dc, 1'b1);
        rd(PARAM_INDEX[SL_FAST_THR], 16'h7333, 1'b1);
        rd(PARAM_INDEX[SL_SLOW_THR], 16'h0ccd, 1'b1);
        rd(24'h380002, 16'h0000, 1'b0);
        $display("test defaults finished");
    endtask : t_defaults

    task automatic t_restart();
        wr(PARAM_INDEX[13 + SL_FWD_TOP], 16'h1000);
        check("marker set", 16'h0001, {15'h0000, marker});
        rd(PARAM_INDEX[13 + SL_FWD_TOP], 16'h1000, 1'b1);
        key_cycle(1'b1);
        wr(PARAM_INDEX[13 + SL_FWD_START], 16'h0800);
        check("marker start", 16'h0001, {15'h0000, marker});
        key_cycle(1'b1);
        for (int i = SL_ACC_FAST; i <= SL_LT_BRK; i++) begin
            wr(PARAM_INDEX[i], 16'h0032);
            wr(PARAM_INDEX[13 + i], 16'h0032);
        end
        check("marker ramps", 16'h0000, {15'h0000, marker});
        $display("test restart finished");
    endtask : t_restart

    task automatic t_mode1();
        drive(16'sd8192, 16'sd0);
        ticks(3);
        check("rising target", 16'h0001,
              {15'h0000, (speedTarget > 16'sd0 && speedTarget < 16'sd1000)});
        ticks(55);
        check("fwd top", 16'h2000, speedTarget);
        drive(-16'sd8192, 16'sd8192);
        ticks(105);
        check("rev top", 16'he000, speedTarget);
        drive(16'sd0, -16'sd8192);
        ticks(55);
        check("neutral", 16'h0000, speedTarget);
        $display("test mode1 finished");
    endtask : t_mode1

    task automatic t_mode2();
        @(posedge clk);
        modeSelPin <= 1'b1;
        drive(16'sd1, 16'sd0);
        ticks(30);
        check("mode2 start", 16'h0800, speedTarget);
        drive(16'sd8192, 16'sd2048);
        ticks(30);
        check("mode2 top", 16'h1000, speedTarget);
        drive(16'sd1, 16'sd4096);
        ticks(30);
        check("partial decel", 16'h0800, speedTarget);
        drive(-16'sd1, 16'sd4096);
        ticks(20);
        check("light brake rev start", 16'h0000, speedTarget);
        $display("test mode2 finished");
    endtask : t_mode2

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    initial begin
        repeat (80000) @(posedge clk);
        failures++;
        test_done();
    end

    initial begin
        rst          = 1'b1;
        keyOnPin     = 1'b1;
        modeSelPin   = 1'b0;
        throttle     = 16'sd0;
        presentSpeed = 16'sd0;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        repeat (6) @(posedge clk);
        t_defaults();
        t_restart();
        t_mode1();
        t_mode2();
        test_done();
    end
endmodule : smr_ramp_profile_test
`default_nettype wire
